/* rtl/mpio_pkg.sv */
package mpio_pkg;
   // widths of the four ports
   localparam int WIDE_W = 8;   // bidirectional port width
   localparam int MIX_W = 8;    // mixed port width
   localparam int MIX_IO_W = 6; // configurable bits of the mixed port
   localparam int OUT_W = 4;    // output-only port width
   localparam int IN_W = 4;     // input-only port width
   // data memory offsets of the port locations
   localparam logic [7:0] OFS_WIDE_DATA = 8'hD0;
   localparam logic [7:0] OFS_WIDE_CFG = 8'hD1;
   localparam logic [7:0] OFS_WIDE_PIN = 8'hD2;
   localparam logic [7:0] OFS_MIX_DATA = 8'hD4;
   localparam logic [7:0] OFS_MIX_CFG = 8'hD5;
   localparam logic [7:0] OFS_MIX_PIN = 8'hD6;
   localparam logic [7:0] OFS_OUT_DATA = 8'hDC;
   localparam logic [7:0] OFS_IN_PIN = 8'hDE;
   // reset values
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [3:0] RST_OUT = 4'hF;
   // bit positions of the mixed port
   localparam int MIX_IRQ_BIT = 0;
   localparam int MIX_TMR_BIT = 3;
   localparam int MIX_SDO_BIT = 4;
   localparam int MIX_SCK_BIT = 5;
   localparam int MIX_SDI_BIT = 6;
   localparam int MIX_HALT_BIT = 7;
   // clock option selections
   typedef enum logic [1:0] {
      MPIO_CLK_CRYSTAL,
      MPIO_CLK_EXTERNAL,
      MPIO_CLK_RC
   } mpio_clk_opt_t;
   // pin drive triple for one port
   typedef struct packed {
      logic [7:0] out;  // level driven
      logic [7:0] oe;   // high while driven
      logic [7:0] pull; // weak pull-up enable
   } mpio_pin_drv_t;
endpackage

/* rtl/mpio_pin_cell.sv */
`timescale 1ns/10ps
// decodes configuration and data bits into pin drive
module mpio_pin_cell #(
   parameter int W = 8
) (
   // register bits
   input wire logic [W-1:0] cfg,
   input wire logic [W-1:0] data,
   // pin drive
   output mpio_pkg::mpio_pin_drv_t drv
);
   // refuse a width that the eight-bit drive triple cannot carry
   if (W < 1 || W > 8) begin : g_bad_width
      $error("mpio_pin_cell width out of range");
   end

   // per pin: 00 float, 01 pull-up, 10 low, 11 high
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_bit
         if (i < W) begin : g_live
            assign drv.oe[i] = cfg[i];
            assign drv.out[i] = cfg[i] & data[i];
            assign drv.pull[i] = ~cfg[i] & data[i];
         end else begin : g_none
            assign drv.oe[i] = 1'b0;
            assign drv.out[i] = 1'b0;
            assign drv.pull[i] = 1'b0;
         end
      end
   endgenerate
endmodule

/* rtl/mpio_port_io.sv */
`timescale 1ns/10ps
module mpio_port_io #(
   parameter mpio_pkg::mpio_clk_opt_t CLK_OPT = mpio_pkg::MPIO_CLK_EXTERNAL
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // data memory access
   input wire logic [7:0] mem_addr,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_rd,
   output logic [7:0] mem_rdata,
   output logic mem_hit,
   // wide bidirectional port
   input wire logic [7:0] wide_in,
   output mpio_pkg::mpio_pin_drv_t wide_drv,
   // mixed port
   input wire logic [7:0] mix_in,
   output mpio_pkg::mpio_pin_drv_t mix_drv,
   // alternate functions of the mixed port
   input wire logic timer_io_out,
   input wire logic timer_io_oe,
   input wire logic serial_do,
   input wire logic serial_clock_out,
   input wire logic serial_clock_oe,
   output logic external_irq_in,
   output logic timer_io_pin,
   output logic serial_clock_pin,
   output logic serial_di,
   // oscillator and halt
   input wire logic osc_input_pin,
   output logic osc_output_pin,
   output logic osc_enable,
   output logic halted,
   output logic halt_continue_pin,
   // output-only and input-only ports
   output logic [3:0] out_port,
   input wire logic [3:0] in_port,
   output logic [3:0] in_port_oe
);
   // registers
   logic [7:0] wide_data_ff;
   logic [7:0] wide_cfg_ff;
   logic [7:0] mix_data_ff;
   logic [5:0] mix_cfg_ff;   // only io bits stored
   logic [3:0] out_ff;
   logic halt_ff;
   logic [7:0] nxt_rdata;
   logic nxt_hit;
   mpio_pkg::mpio_pin_drv_t mix_base;
   logic crystal;

   assign crystal = (CLK_OPT == mpio_pkg::MPIO_CLK_CRYSTAL);

   // refuse a clock option outside the three known ones
   if (CLK_OPT != mpio_pkg::MPIO_CLK_CRYSTAL && CLK_OPT != mpio_pkg::MPIO_CLK_EXTERNAL
       && CLK_OPT != mpio_pkg::MPIO_CLK_RC) begin : g_bad_clk
      $error("mpio_port_io clock option out of range");
   end

   // wide port data register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wide_data_ff <= mpio_pkg::RST_DATA;
      end else if (mem_wr && mem_addr == mpio_pkg::OFS_WIDE_DATA) begin
         wide_data_ff <= mem_wdata;
      end
   end

   // wide port configuration register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wide_cfg_ff <= mpio_pkg::RST_CFG;
      end else if (mem_wr && mem_addr == mpio_pkg::OFS_WIDE_CFG) begin
         wide_cfg_ff <= mem_wdata;
      end
   end

   // mixed port data register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mix_data_ff <= mpio_pkg::RST_DATA;
      end else if (mem_wr && mem_addr == mpio_pkg::OFS_MIX_DATA) begin
         mix_data_ff <= mem_wdata;
      end
   end

   // mixed port configuration, top two bits dropped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mix_cfg_ff <= mpio_pkg::RST_CFG[5:0];
      end else if (mem_wr && mem_addr == mpio_pkg::OFS_MIX_CFG) begin
         mix_cfg_ff <= mem_wdata[5:0];
      end
   end

   // output-only port, high while reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         out_ff <= mpio_pkg::RST_OUT;
      end else if (mem_wr && mem_addr == mpio_pkg::OFS_OUT_DATA) begin
         out_ff <= mem_wdata[3:0];
      end
   end

   // halt: entered by writing data bit 7, left on continue pin high except under the crystal option
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         halt_ff <= 1'b0;
      end else if (mem_wr && mem_addr == mpio_pkg::OFS_MIX_DATA
                   && mem_wdata[mpio_pkg::MIX_HALT_BIT]) begin
         // a halting write wins over a continue in the same cycle
         halt_ff <= 1'b1;
      end else if (halt_ff && !crystal && mix_in[mpio_pkg::MIX_HALT_BIT]) begin
         // continue pin ends halt; the crystal option has no such pin
         halt_ff <= 1'b0;
      end
   end

   // read decode
   always_comb begin
      nxt_rdata = 8'h00;
      nxt_hit = 1'b1;
      case (mem_addr)
         mpio_pkg::OFS_WIDE_DATA: nxt_rdata = wide_data_ff;
         mpio_pkg::OFS_WIDE_CFG: nxt_rdata = wide_cfg_ff;
         mpio_pkg::OFS_WIDE_PIN: nxt_rdata = wide_in;
         mpio_pkg::OFS_MIX_DATA: nxt_rdata = mix_data_ff;
         mpio_pkg::OFS_MIX_CFG: nxt_rdata = {2'b00, mix_cfg_ff};
         mpio_pkg::OFS_MIX_PIN: nxt_rdata = mix_in;
         mpio_pkg::OFS_OUT_DATA: nxt_rdata = {4'h0, out_ff};
         mpio_pkg::OFS_IN_PIN: nxt_rdata = {4'h0, in_port};
         // unmapped addresses read zero and report a miss
         default: nxt_hit = 1'b0;
      endcase
   end

   // registered read data
   // answer holds until the next read strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_rdata <= 8'h00;
         mem_hit <= 1'b0;
      end else if (mem_rd) begin
         mem_rdata <= nxt_rdata;
         mem_hit <= nxt_hit;
      end
   end

   // pin decode of the wide port
   // all eight bits use the four-way decode
   mpio_pin_cell #(
      .W(mpio_pkg::WIDE_W)
   ) u_wide (
      .cfg(wide_cfg_ff),
      .data(wide_data_ff),
      .drv(wide_drv)
   );

   // pin decode of the mixed port io bits
   // bits 6,7 get no cell and stay undriven inputs
   mpio_pin_cell #(
      .W(mpio_pkg::MIX_IO_W)
   ) u_mix (
      .cfg(mix_cfg_ff),
      .data(mix_data_ff[mpio_pkg::MIX_IO_W-1:0]),
      .drv(mix_base)
   );

   // alternate functions override io drive; bits 1,2 plain
   always_comb begin
      mix_drv = mix_base;
      // timer takes bit 3 while it enables its output
      if (mix_cfg_ff[mpio_pkg::MIX_TMR_BIT] && timer_io_oe) begin
         mix_drv.out[mpio_pkg::MIX_TMR_BIT] = timer_io_out;
      end
      // serial data out takes bit 4 when set up as a high output
      if (mix_cfg_ff[mpio_pkg::MIX_SDO_BIT] && mix_data_ff[mpio_pkg::MIX_SDO_BIT]) begin
         mix_drv.out[mpio_pkg::MIX_SDO_BIT] = serial_do;
      end
      // serial clock takes bit 5 while it drives the clock
      if (mix_cfg_ff[mpio_pkg::MIX_SCK_BIT] && serial_clock_oe) begin
         mix_drv.out[mpio_pkg::MIX_SCK_BIT] = serial_clock_out;
      end
      // pull-up on input-only bit 6 still follows data bit 6; bit 7 gets none
      mix_drv.pull[mpio_pkg::MIX_SDI_BIT] = mix_data_ff[mpio_pkg::MIX_SDI_BIT];
   end

   // alternate inputs from the mixed pins
   assign external_irq_in = mix_in[mpio_pkg::MIX_IRQ_BIT];
   assign timer_io_pin = mix_in[mpio_pkg::MIX_TMR_BIT];
   assign serial_clock_pin = mix_in[mpio_pkg::MIX_SCK_BIT];
   assign serial_di = mix_in[mpio_pkg::MIX_SDI_BIT];
   assign halt_continue_pin = crystal ? 1'b0 : mix_in[mpio_pkg::MIX_HALT_BIT];

   // oscillator: feedback output only under crystal option
   assign osc_output_pin = crystal ? ~osc_input_pin : 1'b0;
   // external option keeps its clock running through halt
   assign osc_enable = ~(halt_ff && CLK_OPT != mpio_pkg::MPIO_CLK_EXTERNAL);
   assign halted = halt_ff;

   // fixed ports
   assign out_port = out_ff;
   // input-only port has its drivers held off
   assign in_port_oe = 4'h0;
endmodule

/* tb/mpio_pins_model.sv */
`timescale 1ns/10ps
// board side of one port
module mpio_pins_model (
   // drive from the block
   input wire mpio_pkg::mpio_pin_drv_t drv,
   // board level on undriven pins
   input wire logic [7:0] ext,
   // resolved pin levels
   output logic [7:0] pins
);
   // strong drive wins, weak pull-up beats the board
   assign pins = (drv.oe & drv.out) | (~drv.oe & (drv.pull | ext));
endmodule

/* tb/mpio_port_io_checker.sv */
`timescale 1ns/10ps
// watches the port block at its ports
module mpio_port_io_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // memory side
   input wire logic [7:0] mem_addr,
   input wire logic mem_wr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_rd,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_hit,
   // pins
   input wire logic [7:0] wide_in,
   input wire mpio_pkg::mpio_pin_drv_t wide_drv,
   input wire logic [7:0] mix_in,
   input wire mpio_pkg::mpio_pin_drv_t mix_drv,
   input wire logic external_irq_in,
   input wire logic serial_di,
   input wire logic halted,
   input wire logic osc_enable,
   input wire logic [3:0] out_port
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // config write sets drive enables next cycle
   wide_cfg_a: assert property (
      mem_wr && mem_addr == 8'hD1 |=> wide_drv.oe == $past(mem_wdata)) else $error("wide cfg");
   // data bit lands as output level or pull-up
   wide_data_a: assert property (
      mem_wr && mem_addr == 8'hD0 |=> ((wide_drv.oe & wide_drv.out)
         | (~wide_drv.oe & wide_drv.pull)) == $past(mem_wdata)) else $error("wide data");
   mix_in_only_a: assert property (mix_drv.oe[7:6] == 2'h0) else $error("top bits driven");
   cfg_read_a: assert property (
      mem_rd && mem_addr == 8'hD5 |=> mem_hit && mem_rdata[7:6] == 2'h0) else $error("cfg read");
   pin_read_a: assert property (
      mem_rd && mem_addr == 8'hD2 |=> mem_rdata == $past(wide_in)) else $error("pin read");
   halt_entry_a: assert property (
      mem_wr && mem_addr == 8'hD4 && mem_wdata[7] |=> halted) else $error("no halt");
   osc_stop_a: assert property (halted |-> !osc_enable) else $error("osc runs");
   alt_copy_a: assert property (
      external_irq_in == mix_in[0] && serial_di == mix_in[6]) else $error("alt copy");
   // first edge after reset still shows reset state
   reset_state_a: assert property (
      $fell(rst) |-> out_port == 4'hF && wide_drv.oe == 8'h00) else $error("reset state");
   // main scenarios
   c_halt: cover property ($rose(halted));
   c_pins: cover property (mem_rd && mem_addr == 8'hD2);
   c_cfg: cover property (mem_wr && mem_addr == 8'hD5);
endmodule
bind mpio_port_io mpio_port_io_checker i_mpio_port_io_checker (.clk(clk), .rst(rst),
   .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
   .mem_rdata(mem_rdata), .mem_hit(mem_hit), .wide_in(wide_in), .wide_drv(wide_drv),
   .mix_in(mix_in), .mix_drv(mix_drv), .external_irq_in(external_irq_in),
   .serial_di(serial_di), .halted(halted), .osc_enable(osc_enable), .out_port(out_port));

/* tb/test_mpio_port_io.sv */
`timescale 1ns/10ps
// drives the port block through its memory side
module test_mpio_port_io;
   logic clk, rst, mem_wr, mem_rd, mem_hit, tio_o, tio_oe, tied, halted, osc_en, halt_pin;
   logic irq_pin, tio_pin, sck_pin, sdi_pin, osc_out;
   logic [7:0] mem_addr, mem_wdata, mem_rdata, wide_in, mix_in, ext_w, ext_m;
   logic [3:0] out_port, in_p, in_oe;
   mpio_pkg::mpio_pin_drv_t wide_drv, mix_drv;
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;
   int i;
   // block under test, rc clock option so halt can end
   mpio_port_io #(.CLK_OPT(mpio_pkg::MPIO_CLK_RC)) i_mpio_port_io (.clk(clk), .rst(rst),
      .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rd(mem_rd),
      .mem_rdata(mem_rdata), .mem_hit(mem_hit), .wide_in(wide_in), .wide_drv(wide_drv),
      .mix_in(mix_in), .mix_drv(mix_drv), .timer_io_out(tio_o), .timer_io_oe(tio_oe),
      .serial_do(tied), .serial_clock_out(tied), .serial_clock_oe(tied),
      .external_irq_in(irq_pin), .timer_io_pin(tio_pin), .serial_clock_pin(sck_pin),
      .serial_di(sdi_pin), .osc_input_pin(tied), .osc_output_pin(osc_out),
      .osc_enable(osc_en), .halted(halted),
      .halt_continue_pin(halt_pin), .out_port(out_port), .in_port(in_p), .in_port_oe(in_oe));
   // board models of both ports
   mpio_pins_model i_mpio_pins_model_w (.drv(wide_drv), .ext(ext_w), .pins(wide_in));
   mpio_pins_model i_mpio_pins_model_m (.drv(mix_drv), .ext(ext_m), .pins(mix_in));
   // free running clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 1000) begin
         failures++;
         wrap_up;
      end
   end
   task automatic wrap_up;
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      mem_addr <= a;
      mem_wdata <= d;
      mem_wr <= 1'b1;
      @(posedge clk);
      mem_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h, input string nm);
      @(posedge clk);
      mem_addr <= a;
      mem_rd <= 1'b1;
      @(posedge clk);
      mem_rd <= 1'b0;
      #1;
      chk(nm, e, mem_rdata);
      chk("hit", {7'h0, h}, {7'h0, mem_hit});
   endtask
   // reset held four cycles, output port checked meanwhile
   task automatic do_reset;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("out_port", 8'h0F, {4'h0, out_port});
      @(posedge clk);
      rst <= 1'b0;
   endtask
   initial begin
      {rst, mem_wr, mem_rd, tio_o, tio_oe, tied} = 6'h20;
      {mem_addr, mem_wdata} = 16'h0000;
      ext_w = 8'h5A;
      ext_m = 8'h40;
      in_p = 4'hA;
      do_reset;
      rd(8'hD1, 8'h00, 1'b1, "wide cfg");
      wr(8'hD1, 8'hCC);
      wr(8'hD0, 8'hAA);
      chk("wide oe", 8'hCC, wide_drv.oe);
      chk("wide pull", 8'h22, wide_drv.pull);
      rd(8'hD2, 8'hAA | (~8'hCC & ext_w), 1'b1, "wide pins");
      wr(8'hD5, 8'hFF);
      chk("mix oe", 8'h3F, mix_drv.oe);
      rd(8'hD5, 8'h3F, 1'b1, "mix cfg");
      wr(8'hD4, 8'h05);
      rd(8'hD6, 8'h05 | (~8'h3F & ext_m), 1'b1, "mix pins");
      chk("alt in", 8'h09, {4'h0, irq_pin, tio_pin, sck_pin, sdi_pin});
      tio_oe <= 1'b1;
      tio_o <= 1'b1;
      wr(8'hD4, 8'h00);
      chk("timer out", 8'h01, {7'h0, mix_drv.out[3]});
      tied <= 1'b1;
      wr(8'hD4, 8'h10);
      chk("alt out", 8'h38, mix_drv.out);
      chk("alt in", 8'h07, {4'h0, irq_pin, tio_pin, sck_pin, sdi_pin});
      chk("osc out", 8'h00, {7'h0, osc_out});
      wr(8'hD4, 8'h80);
      chk("halted", 8'h01, {7'h0, halted});
      chk("osc", 8'h00, {7'h0, osc_en});
      ext_m <= 8'hC0;
      i = 0;
      while (halted === 1'b1 && i < 4) begin
         @(posedge clk);
         i++;
      end
      #1;
      chk("resume", 8'h00, {7'h0, halted});
      chk("continue pin", 8'h01, {7'h0, halt_pin});
      chk("osc", 8'h01, {7'h0, osc_en});
      wr(8'hDC, 8'h05);
      chk("out_port", 8'h05, {4'h0, out_port});
      rd(8'hDE, 8'h0A, 1'b1, "in port");
      chk("in oe", 8'h00, {4'h0, in_oe});
      rd(8'h40, 8'h00, 1'b0, "unmapped");
      do_reset;
      rd(8'hD5, 8'h00, 1'b1, "mix cfg");
      rd(8'hD0, 8'h00, 1'b1, "wide data");
      wrap_up;
   end
endmodule
